// ### logic/sss_sequencer.sv
// Purpose: Start-up and VID sequencer of a multiphase buck controller.
// Assumes: Enable, bias and current-monitor levels come from analog comparators.
// Notes: Long delays are parameters so a simulation can shorten them.

`timescale 1ns/10ps
`default_nettype none

module sss_sequencer #(
  parameter int unsigned FIRST_DELAY = sss_pkg::FIRST_DELAY_CYC,
  parameter int unsigned BOOT_HOLD = sss_pkg::BOOT_HOLD_CYC,
  parameter int unsigned READY_DELAY = sss_pkg::READY_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BIAS_POR_OK,
  input wire logic POWER_ENABLE_IN,
  input wire logic TERM_RAIL_ENABLE_IN,
  input wire logic [7:0] VOLTAGE_ID_CODE,
  input wire logic LOW_POWER_REQUEST_N,
  input wire logic LOAD_CURRENT_MONITOR_OVER,
  input wire logic SOFT_START_OSC,
  input wire logic [sss_pkg::OFS_W-1:0] OFFSET_PROGRAM_STEPS,
  output logic [sss_pkg::REF_W-1:0] REFERENCE_CODE,
  output logic PWM_OUTPUT_ENABLE,
  output logic LOW_POWER_MODE,
  output sss_pkg::sss_trip_type TRIP_ADJUST,
  output logic OVERCURRENT_SHUTDOWN,
  output logic REGULATOR_READY_OUT,
  output logic REGULATOR_READY_OUT_OE
);
  import sss_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 14;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic osc_last;

  assign pin_raw = {BIAS_POR_OK, POWER_ENABLE_IN, TERM_RAIL_ENABLE_IN,
                    LOW_POWER_REQUEST_N, LOAD_CURRENT_MONITOR_OVER,
                    SOFT_START_OSC, VOLTAGE_ID_CODE};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_a <= '0;
      sync_b <= '0;
      osc_last <= 1'b0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      osc_last <= sync_b[8];
    end
  end

  wire por_ok = sync_b[13];
  wire pwr_en = sync_b[12];
  wire term_en = sync_b[11];
  wire lp_req_n = sync_b[10];
  wire load_current_monitor_over = sync_b[9];
  wire osc_lvl = sync_b[8];
  wire [7:0] vid_sync = sync_b[7:0];

  // Rising edge of the soft-start oscillator is one ramp step
  wire osc_tick = osc_lvl && !osc_last;

  // ----------------------------------------------------------------
  // VID qualification and target
  // ----------------------------------------------------------------
  sss_vid_type vid;

  sss_vid_qual u_vid_qual (
    .clk(CLK),
    .rst(RST),
    .vid_in(vid_sync),
    .vid(vid)
  );

  logic [REF_W-1:0] vid_volt;
  logic [REF_W-1:0] vid_final;
  logic [REF_W-1:0] ofs_ext;

  // Codes count down from the top of the range in 6.25 mV steps
  assign vid_volt = VID_TOP_CODE - {1'b0, vid.code};
  assign ofs_ext = {{(REF_W-OFS_W){1'b0}}, OFFSET_PROGRAM_STEPS};
  // target is VID less offset, floored at zero
  assign vid_final = (vid_volt > ofs_ext) ? (vid_volt - ofs_ext) : REF_RESET;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sss_state_type state;
  sss_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [REF_W-1:0] target_hold;
  logic [REF_W-1:0] next_target_hold;
  logic [REF_W-1:0] ramp_target;
  logic at_target;
  logic [REF_W-1:0] ref_code;

  wire enable_all = por_ok && pwr_en && term_en;

  wire running = (state != SSS_SHUTDOWN) && (state != SSS_LATCHED_OFF);
  wire first_done = (cnt >= CNT_W'(FIRST_DELAY - 1));
  wire hold_done = (cnt >= CNT_W'(BOOT_HOLD - 1));
  wire ready_done = (cnt >= CNT_W'(READY_DELAY - 1));

  // A new qualified code in regulation moves the target
  wire vid_change = vid.valid && !vid.off && (vid_final != target_hold);

  always_comb begin
    next_state = state;
    unique case (state)
      SSS_SHUTDOWN: begin
        if (enable_all) begin
          next_state = SSS_FIRST_DELAY;
        end
      end
      SSS_FIRST_DELAY: begin
        if (first_done) begin
          next_state = SSS_RAMP_BOOT;
        end
      end
      SSS_RAMP_BOOT: begin
        if (at_target) begin
          next_state = SSS_HOLD_BOOT;
        end
      end
      SSS_HOLD_BOOT: begin
        // fixed hold then wait for a qualified code
        if (hold_done && vid.valid) begin
          next_state = vid.off ? SSS_LATCHED_OFF : SSS_RAMP_VID;
        end
      end
      SSS_RAMP_VID: begin
        if (at_target) begin
          next_state = SSS_READY_DELAY;
        end
      end
      SSS_READY_DELAY: begin
        if (ready_done) begin
          next_state = SSS_REGULATE;
        end
      end
      SSS_REGULATE: begin
        if (vid.valid && vid.off) begin
          next_state = SSS_LATCHED_OFF;
        end
      end
      SSS_LATCHED_OFF: begin
        next_state = SSS_LATCHED_OFF;
      end
    endcase
    // only dropping an enable or the bias reset leaves the latch
    if (!enable_all) begin
      next_state = SSS_SHUTDOWN;
    end else if (running && load_current_monitor_over) begin
      next_state = SSS_LATCHED_OFF;
    end
  end

  assign next_cnt = (next_state != state) ? '0 :
                    ((cnt == {CNT_W{1'b1}}) ? cnt : cnt + 1'b1);

  always_comb begin
    next_target_hold = target_hold;
    if (state == SSS_HOLD_BOOT && hold_done && vid.valid && !vid.off) begin
      // sample the code at the end of the hold
      next_target_hold = vid_final;
    end else if (state == SSS_REGULATE && vid_change) begin
      next_target_hold = vid_final;
    end else if (!running) begin
      next_target_hold = REF_RESET;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= SSS_SHUTDOWN;
      cnt <= '0;
      target_hold <= REF_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      target_hold <= next_target_hold;
    end
  end

  // ----------------------------------------------------------------
  // Reference ramp
  // ----------------------------------------------------------------
  assign ramp_target = (state == SSS_RAMP_BOOT || state == SSS_HOLD_BOOT) ? BOOT_CODE : target_hold;

  wire ramp_run = (state == SSS_RAMP_BOOT) || (state == SSS_RAMP_VID) || (state == SSS_REGULATE);

  sss_ramp u_ramp (
    .clk(CLK),
    .rst(RST),
    .clear(!running),
    .run(ramp_run),
    .tick(osc_tick),
    .target(ramp_target),
    .ref_code(ref_code),
    .at_target(at_target)
  );

  // stepping one code per tick avoids jumps in the output
  wire vid_moving = (state == SSS_REGULATE) && !at_target;
  wire vid_rising = vid_moving && (ref_code < target_hold);

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic ready;
  wire next_ready = (state == SSS_REGULATE) && (next_state == SSS_REGULATE);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REFERENCE_CODE <= REF_RESET;
      PWM_OUTPUT_ENABLE <= 1'b0;
      LOW_POWER_MODE <= 1'b0;
      TRIP_ADJUST <= '0;
      OVERCURRENT_SHUTDOWN <= 1'b0;
      ready <= 1'b0;
    end else begin
      REFERENCE_CODE <= ref_code;
      // drivers see high impedance while shut down
      PWM_OUTPUT_ENABLE <= running && (next_state != SSS_SHUTDOWN) && (next_state != SSS_LATCHED_OFF);
      ready <= next_ready;
      LOW_POWER_MODE <= next_ready && !lp_req_n;
      // widen trips during transitions and step-ups
      TRIP_ADJUST.oc_raised <= vid_moving || vid_rising;
      TRIP_ADJUST.ov_max <= vid_moving || vid_rising;
      if (!enable_all) begin
        OVERCURRENT_SHUTDOWN <= 1'b0;
      end else if (running && load_current_monitor_over) begin
        OVERCURRENT_SHUTDOWN <= 1'b1;
      end
    end
  end

  // Open-drain ready: pull low unless ready
  assign REGULATOR_READY_OUT = 1'b0;
  assign REGULATOR_READY_OUT_OE = !ready;

endmodule : sss_sequencer

`default_nettype wire

// ### logic/sss_pkg.sv
// Purpose: Constants, types and state codes for the soft-start sequencer.
// Assumes: CLK at 250 MHz; comparators outside give digital levels.
// Notes: Reference codes count 6.25 mV steps from zero.
//
// Contract
// - In shutdown every PWM output is high impedance.
// - Leave shutdown only with bias reset risen and both enables above threshold.
// - Wait fixed first delay, 1.36 ms, before any ramp.
// - Ramp reference from zero to 1.1 V boot level, then hold there.
// - Ramps move 6.25 mV per soft-start oscillator period.
// - Boot hold lasts 85 us plus VID validation of at least 500 ns.
// - After hold sample VID; valid code starts ramp to VID minus offset.
// - OFF code shuts down until bias or an enable is cycled.
// - Ready rises 85 us after reference reaches final VID level.
// - Low-power request ignored until ready; normal PWM mode before.
// - Track on-the-fly VID changes stepwise without discontinuity.
// - During VID transition raise overcurrent trip and set overvoltage trip to maximum.
// - Load-current monitor above 1.11 V triggers overcurrent shutdown.
// - VID is 8 bits; all ones and all ones minus bit zero are OFF.
// - Ready held low in shutdown; high only after soft-start plus delay.

package sss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned T_FIRST_DELAY_NS = 1360000;
  localparam int unsigned T_BOOT_HOLD_NS = 85000;
  localparam int unsigned T_VID_QUAL_NS = 500;
  localparam int unsigned T_READY_DELAY_NS = 85000;
  localparam int unsigned FIRST_DELAY_CYC = (T_FIRST_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BOOT_HOLD_CYC = (T_BOOT_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned VID_QUAL_CYC = (T_VID_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned READY_DELAY_CYC = (T_READY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned QUAL_W = 8;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam int unsigned REF_W = 9;
  localparam logic [REF_W-1:0] REF_RESET = 9'h000;
  localparam logic [REF_W-1:0] BOOT_CODE = 9'h0B0;
  localparam logic [REF_W-1:0] VID_TOP_CODE = 9'h102;
  localparam logic [7:0] VID_OFF_A = 8'hFE;
  localparam logic [7:0] VID_OFF_B = 8'hFF;
  localparam logic [7:0] VID_RESET = 8'h00;
  localparam int unsigned OFS_W = 6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSS_SHUTDOWN,
    SSS_FIRST_DELAY,
    SSS_RAMP_BOOT,
    SSS_HOLD_BOOT,
    SSS_RAMP_VID,
    SSS_READY_DELAY,
    SSS_REGULATE,
    SSS_LATCHED_OFF
  } sss_state_type;

  typedef struct packed {
    logic [7:0] code;
    logic valid;
    logic off;
  } sss_vid_type;

  typedef struct packed {
    logic oc_raised;
    logic ov_max;
  } sss_trip_type;

endpackage : sss_pkg

// ### logic/sss_vid_qual.sv
// Purpose: Qualifies the VID code by requiring it to stand still.
// Assumes: Input already synchronised to CLK.
// Notes: Valid drops the cycle after the input code moves, one cycle before the registered code follows.

`timescale 1ns/10ps
`default_nettype none

module sss_vid_qual (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] vid_in,
  output sss_pkg::sss_vid_type vid
);
  import sss_pkg::*;

  logic [7:0] last;
  logic [QUAL_W-1:0] stable;
  logic [QUAL_W-1:0] next_stable;
  logic moved;
  logic qualified;

  assign moved = (vid_in != last);
  assign qualified = (stable >= QUAL_W'(VID_QUAL_CYC - 1));
  assign next_stable = moved ? '0 : (qualified ? stable : stable + 1'b1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= VID_RESET;
      stable <= '0;
      vid <= '0;
    end else begin
      last <= vid_in;
      stable <= next_stable;
      vid.valid <= qualified && !moved;
      vid.code <= last;
      vid.off <= (last == VID_OFF_A) || (last == VID_OFF_B);
    end
  end

endmodule : sss_vid_qual

`default_nettype wire

// ### logic/sss_ramp.sv
// Purpose: Stepped reference code generator.
// Assumes: Tick is a one-cycle pulse per soft-start oscillator period.
// Notes: Moves one step up or down per tick toward the target.

`timescale 1ns/10ps
`default_nettype none

module sss_ramp (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  input wire logic [sss_pkg::REF_W-1:0] target,
  output logic [sss_pkg::REF_W-1:0] ref_code,
  output logic at_target
);
  import sss_pkg::*;

  logic step_up;
  logic step_dn;

  // no step once code equals target
  assign at_target = (ref_code == target);
  assign step_up = run && tick && (ref_code < target);
  assign step_dn = run && tick && (ref_code > target);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_code <= REF_RESET;
    end else if (clear) begin
      ref_code <= REF_RESET;
    end else if (step_up) begin
      // one 6.25 mV step per tick
      ref_code <= ref_code + 1'b1;
    end else if (step_dn) begin
      ref_code <= ref_code - 1'b1;
    end
  end

endmodule : sss_ramp

`default_nettype wire

// ### testbench/sss_sequencer_props.sv
// Purpose: Port-level checks of the soft-start sequencer.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Windows allow for the two-stage input synchronisers.

`timescale 1ns/10ps
`default_nettype none

module sss_sequencer_props #(
  parameter int unsigned FIRST_DELAY = 20,
  parameter int unsigned READY_DELAY = 10
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BIAS_POR_OK,
  input wire logic POWER_ENABLE_IN,
  input wire logic TERM_RAIL_ENABLE_IN,
  input wire logic [7:0] VOLTAGE_ID_CODE,
  input wire logic LOW_POWER_REQUEST_N,
  input wire logic LOAD_CURRENT_MONITOR_OVER,
  input wire logic SOFT_START_OSC,
  input wire logic [sss_pkg::OFS_W-1:0] OFFSET_PROGRAM_STEPS,
  input wire logic [sss_pkg::REF_W-1:0] REFERENCE_CODE,
  input wire logic PWM_OUTPUT_ENABLE,
  input wire logic LOW_POWER_MODE,
  input wire sss_pkg::sss_trip_type TRIP_ADJUST,
  input wire logic OVERCURRENT_SHUTDOWN,
  input wire logic REGULATOR_READY_OUT,
  input wire logic REGULATOR_READY_OUT_OE
);
  import sss_pkg::*;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // --------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------
  logic any_off;
  logic [15:0] on_cnt;
  logic [15:0] still_cnt;
  logic [REF_W-1:0] ref_q;
  assign any_off = !(BIAS_POR_OK && POWER_ENABLE_IN && TERM_RAIL_ENABLE_IN);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      on_cnt <= 16'h0000;
      still_cnt <= 16'h0000;
      ref_q <= 9'h000;
    end else begin
      on_cnt <= !PWM_OUTPUT_ENABLE ? 16'h0000 : (on_cnt == 16'hFFFF ? on_cnt : on_cnt + 16'h0001);
      still_cnt <= (REFERENCE_CODE != ref_q) ? 16'h0000 : (still_cnt == 16'hFFFF ? still_cnt : still_cnt + 16'h0001);
      ref_q <= REFERENCE_CODE;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  chk_shutdown_pwm_off: assert property (any_off [*6] |-> !PWM_OUTPUT_ENABLE)
    else $error("PWM driven while an enable is missing");
  chk_shutdown_ready_low: assert property (any_off [*6] |-> REGULATOR_READY_OUT_OE)
    else $error("ready released while an enable is missing");
  chk_ready_pin_data: assert property (REGULATOR_READY_OUT == 1'b0)
    else $error("ready pin data not low");
  chk_low_power_gate: assert property (REGULATOR_READY_OUT_OE && $past(REGULATOR_READY_OUT_OE) |-> !LOW_POWER_MODE)
    else $error("low-power mode before ready");
  chk_first_delay_wait: assert property (PWM_OUTPUT_ENABLE && REFERENCE_CODE != 9'h000 && ref_q == 9'h000
      |-> on_cnt >= FIRST_DELAY - 1)
    else $error("ramp started before the first delay");
  chk_step_one_code: assert property ($changed(REFERENCE_CODE) && PWM_OUTPUT_ENABLE && REFERENCE_CODE != 9'h000
      |-> (REFERENCE_CODE - ref_q == 9'h001) || (ref_q - REFERENCE_CODE == 9'h001))
    else $error("reference moved by more than one step");
  chk_step_spacing: assert property ($changed(REFERENCE_CODE) && REFERENCE_CODE != 9'h000
      |=> $stable(REFERENCE_CODE) || REFERENCE_CODE == 9'h000)
    else $error("reference stepped on consecutive cycles");
  chk_ready_delay_wait: assert property ($fell(REGULATOR_READY_OUT_OE) |-> still_cnt >= READY_DELAY - 1)
    else $error("ready released too soon after final step");
  chk_trip_pair: assert property (!REGULATOR_READY_OUT_OE && $changed(REFERENCE_CODE)
      |-> $past(TRIP_ADJUST.oc_raised) && $past(TRIP_ADJUST.ov_max))
    else $error("reference moved in regulation without widened trips");
  chk_overcurrent_trip: assert property ($rose(LOAD_CURRENT_MONITOR_OVER) && PWM_OUTPUT_ENABLE && !any_off
      |-> ##[1:6] OVERCURRENT_SHUTDOWN)
    else $error("overcurrent not flagged");
  chk_overcurrent_off: assert property (OVERCURRENT_SHUTDOWN [*3] |-> !PWM_OUTPUT_ENABLE)
    else $error("PWM driven after overcurrent");

  cov_ready: cover property ($fell(REGULATOR_READY_OUT_OE));
  cov_move: cover property ($rose(TRIP_ADJUST.oc_raised));
  cov_trip: cover property ($rose(OVERCURRENT_SHUTDOWN));
endmodule : sss_sequencer_props

bind sss_sequencer sss_sequencer_props #(.FIRST_DELAY(FIRST_DELAY), .READY_DELAY(READY_DELAY)) u_props (
  .CLK(CLK), .RST(RST), .BIAS_POR_OK(BIAS_POR_OK), .POWER_ENABLE_IN(POWER_ENABLE_IN),
  .TERM_RAIL_ENABLE_IN(TERM_RAIL_ENABLE_IN), .VOLTAGE_ID_CODE(VOLTAGE_ID_CODE),
  .LOW_POWER_REQUEST_N(LOW_POWER_REQUEST_N), .LOAD_CURRENT_MONITOR_OVER(LOAD_CURRENT_MONITOR_OVER),
  .SOFT_START_OSC(SOFT_START_OSC), .OFFSET_PROGRAM_STEPS(OFFSET_PROGRAM_STEPS), .REFERENCE_CODE(REFERENCE_CODE),
  .PWM_OUTPUT_ENABLE(PWM_OUTPUT_ENABLE), .LOW_POWER_MODE(LOW_POWER_MODE), .TRIP_ADJUST(TRIP_ADJUST),
  .OVERCURRENT_SHUTDOWN(OVERCURRENT_SHUTDOWN), .REGULATOR_READY_OUT(REGULATOR_READY_OUT),
  .REGULATOR_READY_OUT_OE(REGULATOR_READY_OUT_OE));

`default_nettype wire

// ### testbench/sss_cpu_model.sv
// Purpose: Processor side: drives the code and the low-power request.
// Assumes: Commands come from the bench on the same clock.
// Notes: Never moves the code while the request is asserted.

`timescale 1ns/10ps
`default_nettype none

module sss_cpu_model #(
  // 50 us of low-power holdoff at 4 ns per cycle
  parameter int unsigned REENTRY = 12500
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] want_code,
  input wire logic want_low_power,
  input wire logic moving,
  output logic [7:0] id_code,
  output logic low_power_request_n
);
  import sss_pkg::*;
  logic [15:0] settle;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_code <= VID_RESET;
      low_power_request_n <= 1'b1;
      settle <= 16'h0000;
    end else if (id_code != want_code) begin
      if (!low_power_request_n) begin
        // Holdoff is owed only for a move made in low power
        low_power_request_n <= 1'b1;
        settle <= REENTRY[15:0];
      end else begin
        id_code <= want_code;
      end
    end else if (moving && settle != 16'h0000) begin
      settle <= REENTRY[15:0];
    end else if (settle != 16'h0000) begin
      settle <= settle - 16'h0001;
    end else begin
      low_power_request_n <= !want_low_power;
    end
  end
endmodule : sss_cpu_model

`default_nettype wire

// ### testbench/test_soft_start_sequencer.sv
// Purpose: Self-checking bench of the soft-start sequencer.
// Assumes: Delays shortened to 20/10/10 cycles; oscillator period 8 cycles.
// Notes: Results are matched in order against a queue of notes.

`timescale 1ns/10ps
`default_nettype none

module test_soft_start_sequencer;
  import sss_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [REF_W-1:0] level;
  } sss_note_type;

  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [2:0] en = 3'b000;
  logic mon = 1'b0;
  logic osc = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  logic [5:0] ofs = 6'h00;
  logic [7:0] want_code = 8'h40;
  logic want_lp = 1'b1;
  logic [7:0] id_code;
  logic lp_n;
  logic [REF_W-1:0] ref_code;
  logic pwm_en;
  logic lp_mode;
  sss_trip_type trip;
  logic oc;
  logic rdy;
  logic rdy_oe;
  logic prev_oe = 1'b1;
  logic prev_pwm = 1'b0;
  logic prev_move = 1'b0;
  logic [7:0] code = 8'h40;
  logic [31:0] seed = 32'h000038A2;
  sss_note_type notes[$];
  int mismatches = 0;
  int total_checks = 0;

  sss_sequencer #(.FIRST_DELAY(20), .BOOT_HOLD(10), .READY_DELAY(10)) u_dut (
    .CLK(CLK), .RST(RST), .BIAS_POR_OK(en[2]), .POWER_ENABLE_IN(en[1]), .TERM_RAIL_ENABLE_IN(en[0]),
    .VOLTAGE_ID_CODE(id_code), .LOW_POWER_REQUEST_N(lp_n), .LOAD_CURRENT_MONITOR_OVER(mon),
    .SOFT_START_OSC(osc), .OFFSET_PROGRAM_STEPS(ofs), .REFERENCE_CODE(ref_code), .PWM_OUTPUT_ENABLE(pwm_en),
    .LOW_POWER_MODE(lp_mode), .TRIP_ADJUST(trip), .OVERCURRENT_SHUTDOWN(oc), .REGULATOR_READY_OUT(rdy),
    .REGULATOR_READY_OUT_OE(rdy_oe));

  sss_cpu_model u_cpu (.clk(CLK), .rst(RST), .want_code(want_code), .want_low_power(want_lp),
    .moving(trip.oc_raised), .id_code(id_code), .low_power_request_n(lp_n));

  initial begin
    forever #2 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc <= osc_cnt[2];
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  function automatic void roll();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction : roll

  function automatic logic [REF_W-1:0] goal(input logic [7:0] c, input logic [5:0] o);
    int t;
    t = 258 - int'(c) - int'(o);
    return (t < 0) ? 9'h000 : REF_W'(t);
  endfunction : goal

  task automatic take(input logic [1:0] kind);
    sss_note_type n;
    if (notes.size() == 0) begin
      check({14'h0000, kind}, 16'h0000);
    end else begin
      n = notes.pop_front();
      check({14'h0000, kind}, {14'h0000, n.kind});
      if (kind != 2'h3) check({7'h00, ref_code}, {7'h00, n.level});
    end
  endtask : take

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST === 1'b0) begin
      if (prev_oe === 1'b1 && rdy_oe === 1'b0) take(2'h1);
      if (prev_move === 1'b1 && trip.oc_raised === 1'b0) take(2'h2);
      if (prev_pwm === 1'b1 && pwm_en === 1'b0) take(2'h3);
    end
    prev_oe = rdy_oe;
    prev_move = trip.oc_raised;
    prev_pwm = pwm_en;
  end

  task automatic drain(input int limit);
    for (int n = 0; n < limit && notes.size() != 0; n++) @(posedge CLK);
    if (notes.size() != 0) begin
      mismatches++;
      $display("mismatch at %0t: result missing", $time);
      complete_run();
    end
  endtask : drain

  task automatic arm(input logic [7:0] c);
    roll();
    code = c;
    @(posedge CLK);
    en <= 3'b000;
    ofs <= {4'h0, seed[1:0]};
    want_code <= c;
    repeat (10) @(posedge CLK);
    en <= 3'b111;
  endtask : arm

  task automatic hold_off(input int cycles);
    repeat (cycles) @(posedge CLK);
    check({15'h0000, pwm_en}, 16'h0000);
  endtask : hold_off

  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK);
      en <= 3'b111 ^ (3'b001 << i);
      repeat (40) @(posedge CLK);
      check({15'h0000, pwm_en}, 16'h0000);
      check({15'h0000, rdy_oe}, 16'h0001);
    end
    roll();
    arm(8'h40 + {3'h0, seed[4:0]});
    notes.push_back(sss_note_type'{2'h1, goal(code, ofs)});
    drain(4000);
    // Processor holds off low power for 50 us after the start-up code change
    for (int n = 0; n < 15000 && lp_mode !== 1'b1; n++) @(posedge CLK);
    check({15'h0000, lp_mode}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      roll();
      code = seed[2] ? code + 8'h01 + {6'h00, seed[1:0]} : code - 8'h01 - {6'h00, seed[1:0]};
      notes.push_back(sss_note_type'{2'h2, goal(code, ofs)});
      @(posedge CLK);
      want_code <= code;
      drain(4000);
    end
    notes.push_back(sss_note_type'{2'h3, 9'h000});
    @(posedge CLK);
    want_code <= VID_OFF_A;
    drain(500);
    @(posedge CLK);
    want_code <= code;
    hold_off(300);
    arm(VID_OFF_B);
    notes.push_back(sss_note_type'{2'h3, 9'h000});
    drain(4000);
    hold_off(100);
    arm(8'h48);
    for (int n = 0; n < 3000 && ref_code < 9'h020; n++) @(posedge CLK);
    check({15'h0000, ref_code >= 9'h020}, 16'h0001);
    notes.push_back(sss_note_type'{2'h3, 9'h000});
    @(posedge CLK);
    mon <= 1'b1;
    drain(50);
    repeat (3) @(posedge CLK);
    check({15'h0000, oc}, 16'h0001);
    mon <= 1'b0;
    hold_off(100);
    check(16'(notes.size()), 16'h0000);
    complete_run();
  end
endmodule : test_soft_start_sequencer

`default_nettype wire
